//--- rld_pkg.sv
// package: constants and carrier types of the remote load header detector
package rld_pkg;

  // header and trailer codes, chosen per installation at build time
  localparam logic [7:0] CODE_BOOT = 8'h1b;
  localparam logic [7:0] CODE_ADDR1 = 8'h41;
  localparam logic [7:0] CODE_ADDR2 = 8'h42;
  localparam logic [7:0] CODE_GEN = 8'h2a;
  localparam logic [7:0] CODE_ERR = 8'h3f;
  localparam logic [7:0] CODE_EOB = 8'h04;

  // clock and timing
  localparam longint unsigned CLK_HZ = 40_000_000;
  localparam longint unsigned TX_TIMEOUT_S = 60;
  localparam logic [31:0] TX_TIMEOUT_CYC = 32'(TX_TIMEOUT_S * CLK_HZ);
  localparam logic [1:0] FAIL_HOLD_CYC = 2'h2;
  localparam logic [2:0] KEY_COUNT = 3'h5;

  // register map, one word per register
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR = 4'h8;

  // control register fields
  localparam int CTRL_TIMEOUT_EN_BIT = 0;
  localparam int CTRL_ENTER_BOOT_BIT = 1;
  localparam logic CTRL_TIMEOUT_EN_RST = 1'b1;

  // status register fields
  localparam int ST_STAGE_ONE_BIT = 0;
  localparam int ST_STAGE_TWO_BIT = 1;
  localparam int ST_STAGE_THREE_BIT = 2;
  localparam int ST_STAGE_FOUR_BIT = 3;
  localparam int ST_ACK_EN_BIT = 4;
  localparam int ST_BOOT_LATCH_BIT = 5;
  localparam int ST_BOOT_REQ_BIT = 6;

  typedef struct packed {
    logic [7:0] data;   // rx_char_bit7 .. rx_char_bit0
    logic avail;        // char_avail_strobe
  } rld_rx_t;

  typedef struct packed {
    logic boot_req_n;
    logic ack_n;
    logic find_sync;
  } rld_proc_t;

endpackage

//--- rld_top.sv
// remote load header detector: header search, boot request, acknowledge and recovery
//
// Summary of operation
// [R1] each received eight-bit character is compared with all configured codes
// [R2] header and end codes are build-time constants in the package
// [R3] header is boot, boot, address one or general, then second/general/error
// [R4] first boot match needs the strobe and a clear second stage
// [R5] stage flags stay set until the common detector clear
// [R6] non-boot second character clears all flags and restarts search
// [R7] third stage sets on strobe from stage two with address one or general
// [R8] third character mismatch clears all flags
// [R9] fourth stage sets on strobe from stage three with second, general or error
// [R10] fourth character mismatch clears all flags
// [R11] fourth stage drives the active-low boot request
// [R12] acknowledge enable sets on the next strobe after fourth stage, never clears alone
// [R13] acknowledge low when enabled, controller select low and type bit low
// [R14] end-of-boot in fourth stage with strobe clears flags and drops boot request
// [R15] transmit mode longer than one minute forces boot mode again
// [R16] concealed switch plus five keyed characters forces failure mode
// [R17] loss of modem carrier forces boot mode again
// [R18] a new header before end-of-boot restarts detection and keeps boot mode
// [R19] specific addressing needs both own address codes
// [R20] both general accepts all; general second needs own first address
// [R21] general then error accepted only when already in boot and not yet loading
// [R22] entering boot mode pulses the sync search request
// [R23] reset clears all flags and leaves the boot request inactive
// [R24] the character is sampled once, in the strobe cycle only
//
// Our own choices: the address-and-strobe port and the register addresses.
module rld_top
  import rld_pkg::*;
#(
  parameter logic [31:0] TX_TIMEOUT = TX_TIMEOUT_CYC
) (
  input wire logic clock,                 // system clock, 40 MHz
  input wire logic resetn,                // async reset, active low
  input wire rld_rx_t rx,                 // received character and its strobe
  input wire logic controller_select_n,   // controller address select, low active
  input wire logic type_bit_one,          // processor type bit 01
  input wire logic xmit_mode,             // line controller in transmit mode
  input wire logic carrier_pin,           // modem carrier detect pin, high = carrier
  input wire logic boot_switch_pin,       // concealed boot switch pin, high = pressed
  input wire logic key_strobe,            // keyboard character entered
  input wire logic [3:0] reg_addr,        // register byte address
  input wire logic [31:0] reg_wdata,      // register write data
  input wire logic reg_wr,                // write strobe
  input wire logic reg_rd,                // read strobe
  output logic [31:0] reg_rdata,          // read data, cycle after the read strobe
  output rld_proc_t proc                  // boot request, acknowledge, sync search
);

  logic stage_one_q;
  logic stage_two_q;
  logic stage_three_flag;
  logic stage_four_flag;
  logic gen_first_q;
  logic ack_enable_flag;
  logic boot_latch_q;
  logic [1:0] fail_hold_q;
  logic timeout_en_q;
  logic [31:0] tx_cnt_q;
  logic [2:0] key_cnt_q;
  logic carrier_s1_q, carrier_s2_q, carrier_prev_q;
  logic switch_s1_q, switch_s2_q;
  logic boot_out_prev_q;

  // character decode, only meaningful in the strobe cycle
  logic char_avail_strobe;
  logic header_char_match;
  logic addr1_match;
  logic general_error_match;
  logic is_error;
  logic second_addr_match_n;
  logic end_char_match;
  logic stage_four_ok;

  assign char_avail_strobe = rx.avail; // R24
  assign header_char_match = (rx.data == CODE_BOOT); // R1 R2
  assign addr1_match = (rx.data == CODE_ADDR1); // R1
  assign general_error_match = (rx.data == CODE_GEN); // R1
  assign is_error = (rx.data == CODE_ERR); // R1
  assign end_char_match = (rx.data == CODE_EOB); // R1

  // accepted fourth character depends on how the third was matched
  assign stage_four_ok = ((rx.data == CODE_ADDR2) && !gen_first_q) // R19
                       || general_error_match // R20
                       || (is_error && gen_first_q && boot_latch_q); // R21
  assign second_addr_match_n = !stage_four_ok;

  // stage steps, each qualified by the strobe
  logic first_char_qualify, stage_one_clock, stage_two_set, bad_second;
  logic stage_three_set, bad_third, stage_four_set, bad_fourth;
  logic eob_seen, restart_seen, fail_evt, detector_clear;

  assign first_char_qualify = char_avail_strobe && !stage_two_q; // R4
  assign stage_one_clock = first_char_qualify && header_char_match && !stage_one_q; // R4
  assign stage_two_set = first_char_qualify && stage_one_q && header_char_match; // R3
  assign bad_second = first_char_qualify && stage_one_q && !header_char_match; // R6
  assign stage_three_set = char_avail_strobe && stage_two_q && !stage_three_flag
                         && (addr1_match || general_error_match); // R7
  assign bad_third = char_avail_strobe && stage_two_q && !stage_three_flag
                   && !(addr1_match || general_error_match); // R8
  assign stage_four_set = char_avail_strobe && stage_three_flag && !stage_four_flag
                        && !second_addr_match_n; // R9
  assign bad_fourth = char_avail_strobe && stage_three_flag && !stage_four_flag
                    && second_addr_match_n; // R10
  assign eob_seen = char_avail_strobe && stage_four_flag && end_char_match; // R14
  assign restart_seen = char_avail_strobe && stage_four_flag && header_char_match; // R18

  // failure sources
  logic tx_timeout, carrier_lost, manual_fail, sw_enter;
  assign tx_timeout = timeout_en_q && xmit_mode && (tx_cnt_q == TX_TIMEOUT - 32'h1); // R15
  assign carrier_lost = carrier_prev_q && !carrier_s2_q; // R17
  assign manual_fail = switch_s2_q && key_strobe && (key_cnt_q == KEY_COUNT - 3'h1); // R16
  assign sw_enter = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_ENTER_BOOT_BIT];
  assign fail_evt = tx_timeout || carrier_lost || manual_fail;

  // mismatches, end of load, restart and failures all share this one clear
  assign detector_clear = bad_second || bad_third || bad_fourth || eob_seen
                        || restart_seen || fail_evt;

  // stage flags: set only, cleared by the common clear; a restart boot char re-arms stage one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage_one_q <= 1'b0; // R23
      stage_two_q <= 1'b0;
      stage_three_flag <= 1'b0;
      stage_four_flag <= 1'b0;
      gen_first_q <= 1'b0;
    end else begin
      if (restart_seen) begin
        stage_one_q <= 1'b1; // R18
      end else if (detector_clear) begin
        stage_one_q <= 1'b0; // R6
      end else if (stage_one_clock) begin
        stage_one_q <= 1'b1; // R5
      end
      if (detector_clear) begin
        stage_two_q <= 1'b0;
        stage_three_flag <= 1'b0; // R8
        stage_four_flag <= 1'b0; // R10
        gen_first_q <= 1'b0;
      end else begin
        if (stage_two_set) begin
          stage_two_q <= 1'b1; // R3
        end
        if (stage_three_set) begin
          stage_three_flag <= 1'b1; // R7
          gen_first_q <= general_error_match && !addr1_match;
        end
        if (stage_four_set) begin
          stage_four_flag <= 1'b1; // R9
        end
      end
    end
  end

  // acknowledge enable: set on the strobe after the fourth stage is already set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_enable_flag <= 1'b0; // R23
    end else if (detector_clear) begin
      ack_enable_flag <= 1'b0;
    end else if (char_avail_strobe && stage_four_flag) begin
      ack_enable_flag <= 1'b1; // R12
    end
  end

  // boot latch: failure entry without acknowledge until end-of-boot arrives in the fourth stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      boot_latch_q <= 1'b0;
      fail_hold_q <= 2'h0;
    end else begin
      if (fail_evt || sw_enter || restart_seen) begin
        boot_latch_q <= 1'b1; // R15
      end else if (eob_seen) begin
        boot_latch_q <= 1'b0; // R14
      end
      // the processor sees boot only after the flags had time to clear
      if (fail_evt) begin
        fail_hold_q <= FAIL_HOLD_CYC;
      end else if (fail_hold_q != 2'h0) begin
        fail_hold_q <= fail_hold_q - 2'h1;
      end
    end
  end

  // transmit watchdog; counts only while transmitting, so idle time never trips it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_q <= 32'h0;
    end else if (!xmit_mode || !timeout_en_q || tx_timeout) begin
      tx_cnt_q <= 32'h0;
    end else begin
      tx_cnt_q <= tx_cnt_q + 32'h1; // R15
    end
  end

  // pin synchronisers; carrier edge taken from the second stage only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      carrier_s1_q <= 1'b0;
      carrier_s2_q <= 1'b0;
      carrier_prev_q <= 1'b0;
      switch_s1_q <= 1'b0;
      switch_s2_q <= 1'b0;
    end else begin
      carrier_s1_q <= carrier_pin;
      carrier_s2_q <= carrier_s1_q;
      carrier_prev_q <= carrier_s2_q; // R17
      switch_s1_q <= boot_switch_pin;
      switch_s2_q <= switch_s1_q;
    end
  end

  // manual entry: keys count only while the switch is held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      key_cnt_q <= 3'h0;
    end else if (!switch_s2_q || manual_fail) begin
      key_cnt_q <= 3'h0;
    end else if (key_strobe) begin
      key_cnt_q <= key_cnt_q + 3'h1; // R16
    end
  end

  // processor side outputs, all registered
  logic boot_out_d;
  assign boot_out_d = stage_four_flag || (boot_latch_q && (fail_hold_q == 2'h0));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      proc.boot_req_n <= 1'b1; // R23
      proc.ack_n <= 1'b1;
      proc.find_sync <= 1'b0;
      boot_out_prev_q <= 1'b0;
    end else begin
      proc.boot_req_n <= !boot_out_d; // R11
      proc.ack_n <= !(ack_enable_flag && !controller_select_n && !type_bit_one); // R13
      boot_out_prev_q <= boot_out_d;
      proc.find_sync <= boot_out_d && !boot_out_prev_q; // R22
    end
  end

  // register port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timeout_en_q <= CTRL_TIMEOUT_EN_RST;
    end else if (reg_wr && (reg_addr == REG_CTRL)) begin
      timeout_en_q <= reg_wdata[CTRL_TIMEOUT_EN_BIT];
    end
  end

  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[ST_STAGE_ONE_BIT] = stage_one_q;
    status_w[ST_STAGE_TWO_BIT] = stage_two_q;
    status_w[ST_STAGE_THREE_BIT] = stage_three_flag;
    status_w[ST_STAGE_FOUR_BIT] = stage_four_flag;
    status_w[ST_ACK_EN_BIT] = ack_enable_flag;
    status_w[ST_BOOT_LATCH_BIT] = boot_latch_q;
    status_w[ST_BOOT_REQ_BIT] = !proc.boot_req_n;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {31'h0, timeout_en_q};
        REG_STATUS: reg_rdata <= status_w;
        REG_ADDR: reg_rdata <= {16'h0, CODE_ADDR2, CODE_ADDR1};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // one fixed gap keeps the check cheap; other gaps rely on the same set logic
  sequence two_boots;
    (char_avail_strobe && header_char_match && !stage_one_q && !stage_two_q && !fail_evt)
    ##1 (!char_avail_strobe && !fail_evt) [*3]
    ##1 (char_avail_strobe && header_char_match && !fail_evt);
  endsequence

  chk_first_boot_set: assert property ( // R4
    char_avail_strobe && header_char_match && !stage_one_q && !stage_two_q && !fail_evt |=> stage_one_q)
    else $error("first boot char did not set stage one");
  chk_two_boot_seq: assert property (two_boots |=> stage_two_q) // R3
    else $error("two boot chars did not set stage two");
  chk_stage_hold: assert property ($rose(stage_two_q) |-> stage_two_q [*2] or detector_clear) // R5
    else $error("stage two dropped without clear");
  chk_bad_second: assert property ( // R6
    char_avail_strobe && stage_one_q && !stage_two_q && !header_char_match |=> !stage_one_q)
    else $error("bad second char kept stage one");
  chk_third_set: assert property ( // R7
    char_avail_strobe && stage_two_q && !stage_three_flag && addr1_match && !fail_evt |=> stage_three_flag)
    else $error("third stage not set");
  chk_third_bad: assert property (bad_third |=> !stage_two_q && !stage_three_flag) // R8
    else $error("bad third char kept flags");
  chk_fourth_set: assert property (stage_four_set && !fail_evt |=> stage_four_flag) // R9
    else $error("fourth stage not set");
  chk_fourth_bad: assert property (bad_fourth |=> !stage_three_flag && !stage_one_q) // R10
    else $error("bad fourth char kept flags");
  chk_boot_request: assert property (stage_four_flag |=> !proc.boot_req_n) // R11
    else $error("boot request missing in fourth stage");
  chk_ack_gate: assert property ( // R13
    ack_enable_flag && !controller_select_n && !type_bit_one |=> !proc.ack_n)
    else $error("acknowledge not driven");
  chk_eob_release: assert property ( // R14
    eob_seen && !fail_evt && !sw_enter |=> !stage_four_flag && !boot_latch_q ##1 proc.boot_req_n)
    else $error("end of boot did not release");
  chk_timeout_boot: assert property (tx_timeout |=> boot_latch_q && !stage_four_flag ##[2:3] !proc.boot_req_n) // R15
    else $error("transmit timeout did not force boot");
  chk_sync_search: assert property ($fell(proc.boot_req_n) |-> proc.find_sync) // R22
    else $error("no sync search on boot entry");

  // failure entries: flags drop at once, the boot request follows after the hold
  sequence latch_then_boot;
    boot_latch_q && !stage_four_flag ##[2:3] !proc.boot_req_n;
  endsequence

  // a restart boot char re-arms stage one while the boot request stays low
  sequence restart_rearm;
    stage_one_q && !stage_two_q && boot_latch_q ##1 !proc.boot_req_n;
  endsequence

  // addressing classes at the fourth character
  chk_specific_accept: assert property ( // R19
    char_avail_strobe && stage_three_flag && !stage_four_flag && !gen_first_q && (rx.data == CODE_ADDR2)
    && !fail_evt |=> stage_four_flag)
    else $error("specific address not accepted");
  chk_general_accept: assert property ( // R20
    char_avail_strobe && stage_three_flag && !stage_four_flag && general_error_match
    && !fail_evt |=> stage_four_flag)
    else $error("general address not accepted");
  chk_error_refused: assert property ( // R21
    char_avail_strobe && stage_three_flag && !stage_four_flag && is_error && !boot_latch_q |=> !stage_four_flag)
    else $error("error address accepted outside boot");

  // acknowledge path
  chk_ack_set: assert property ( // R12
    char_avail_strobe && stage_four_flag && !detector_clear |=> ack_enable_flag)
    else $error("acknowledge enable not set");
  chk_ack_idle: assert property (!ack_enable_flag |=> proc.ack_n) // R13
    else $error("acknowledge without enable");
  chk_eob_ack_drop: assert property (eob_seen |=> !ack_enable_flag && !stage_one_q) // R14
    else $error("end of boot kept acknowledge enable");
  chk_latch_hold: assert property (boot_latch_q && !eob_seen |=> boot_latch_q) // R14
    else $error("boot latch dropped without end of boot");

  // recovery paths
  chk_carrier_boot: assert property (carrier_lost |=> latch_then_boot) // R17
    else $error("carrier loss did not force boot");
  chk_manual_boot: assert property (manual_fail |=> latch_then_boot) // R16
    else $error("manual entry did not force boot");
  chk_restart_keep: assert property (restart_seen && !fail_evt |=> restart_rearm) // R18
    else $error("restart did not keep boot mode");
  chk_hold_blocks: assert property (fail_hold_q != 2'h0 && !stage_four_flag |=> proc.boot_req_n) // R15
    else $error("boot request raised during hold");

  // counters, pulses and strobe qualification
  chk_watchdog_idle: assert property (!xmit_mode |=> tx_cnt_q == 32'h0) // R15
    else $error("watchdog counted outside transmit");
  chk_key_idle: assert property (!switch_s2_q |=> key_cnt_q == 3'h0) // R16
    else $error("keys counted without switch");
  chk_sync_pulse: assert property (proc.find_sync |=> !proc.find_sync) // R22
    else $error("sync search longer than one cycle");
  chk_strobe_only: assert property ( // R24
    !char_avail_strobe && !fail_evt |=> $stable({stage_one_q, stage_two_q, stage_three_flag, stage_four_flag}))
    else $error("stage flags moved without a strobe");

endmodule

//--- rld_line_model.sv
// line controller model: one-cycle character strobes to the detector
module rld_line_model
  import rld_pkg::*;
(
  input wire logic clock,         // system clock
  input wire logic resetn,        // async reset, active low
  input wire logic send,          // send one character
  input wire logic [7:0] char_in, // character to send
  output rld_rx_t rx              // character and strobe to the detector
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx <= '0;
    end else begin
      rx.avail <= send;
      // between characters the data lines mean nothing, so they toggle
      rx.data <= send ? char_in : ~rx.data;
    end
  end
endmodule

//--- remote_load_header_detector_bench.sv
// self-checking bench for the remote load header detector
module remote_load_header_detector_bench
  import rld_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] A3[3] = '{CODE_ADDR1, CODE_GEN, CODE_ADDR1};
  localparam logic [7:0] A4[3] = '{CODE_ADDR2, CODE_GEN, CODE_GEN};
  localparam logic [31:0] REJ[4] = '{{CODE_BOOT, 8'h55, 16'h0}, {CODE_BOOT, CODE_BOOT, CODE_GEN, CODE_ADDR2},
    {CODE_BOOT, CODE_BOOT, CODE_GEN, CODE_ERR}, {CODE_BOOT, CODE_BOOT, CODE_ADDR2, 8'h00}};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic send = 1'b0;
  logic [7:0] char_in = 8'h00;
  logic sel_n = 1'b0, type1 = 1'b0, xmit = 1'b0, carrier = 1'b1, sw = 1'b0, key = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] c;
  rld_rx_t rx;
  rld_proc_t proc;
  int num_errors = 0, compares = 0, fs_count = 0, f;
  logic [31:0] exp_q[$];

  always #12.5 clock = ~clock;

  rld_line_model rld_line_model_i (.clock(clock), .resetn(resetn), .send(send), .char_in(char_in), .rx(rx));
  // short timeout count keeps the run brief
  rld_top #(.TX_TIMEOUT(32'h32)) rld_top_i (.clock(clock), .resetn(resetn), .rx(rx),
    .controller_select_n(sel_n), .type_bit_one(type1), .xmit_mode(xmit), .carrier_pin(carrier),
    .boot_switch_pin(sw), .key_strobe(key), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .proc(proc));

  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (proc.find_sync === 1'b1) fs_count <= fs_count + 1;
  end
  // read data stand only in the cycle after the strobe, so look there
  always @(negedge clock) if (rd_d) cmp_word("reg_rdata", exp_q.pop_front(), reg_rdata);

  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_bit(input string what, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
    cyc(1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic put(input logic [7:0] ch);
    @(posedge clock);
    send <= 1'b1;
    char_in <= ch;
    @(posedge clock);
    send <= 1'b0;
    cyc(2);
  endtask
  task automatic seq(input logic [31:0] s);
    for (int i = 3; i >= 0; i--) if (s[8*i+:8] != 8'h00) put(s[8*i+:8]);
  endtask
  task automatic wait_boot(input logic e);
    int n;
    n = 0;
    while (proc.boot_req_n !== e && n < 400) begin
      cyc(1);
      n++;
    end
    cmp_bit("boot_req_n", e, proc.boot_req_n);
    if (n == 400) results();
  endtask
  // error addressing header, then end of load, back to idle
  task automatic finish_boot();
    seq({CODE_BOOT, CODE_BOOT, CODE_GEN, CODE_ERR});
    put(CODE_EOB);
    rd(REG_STATUS, 32'h0);
    wait_boot(1'b1);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h84054f0c));
    cyc(20);
    resetn <= 1'b1;
    cyc(4);
    rd(REG_STATUS, 32'h0);
    rd(REG_CTRL, 32'h1);
    rd(REG_ADDR, {16'h0, CODE_ADDR2, CODE_ADDR1});
    rd(4'hc, 32'h0);
    cmp_bit("boot_req_n", 1'b1, proc.boot_req_n);
    put(CODE_BOOT);
    rd(REG_STATUS, 32'h1);
    put(CODE_BOOT);
    rd(REG_STATUS, 32'h3);
    put(CODE_ADDR1);
    rd(REG_STATUS, 32'h7);
    put(8'h55);
    rd(REG_STATUS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      f = fs_count;
      seq({CODE_BOOT, CODE_BOOT, A3[i], A4[i]});
      cyc(3);
      cmp_bit("boot_req_n", 1'b0, proc.boot_req_n);
      rd(REG_STATUS, 32'h4f);
      cmp_word("find_sync", 32'h1, 32'(fs_count - f));
      if (i == 0) begin
        put(8'h10);
        rd(REG_STATUS, 32'h5f);
        cmp_bit("ack_n", 1'b0, proc.ack_n);
        type1 <= 1'b1;
        cyc(3);
        cmp_bit("ack_n", 1'b1, proc.ack_n);
        type1 <= 1'b0;
        seq({CODE_BOOT, CODE_BOOT, CODE_ADDR1, CODE_ADDR2});
        rd(REG_STATUS, 32'h6f);
      end
      put(CODE_EOB);
      rd(REG_STATUS, 32'h0);
      wait_boot(1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      seq(REJ[i]);
      rd(REG_STATUS, 32'h0);
      cmp_bit("boot_req_n", 1'b1, proc.boot_req_n);
    end
    xmit <= 1'b1;
    cyc(60);
    xmit <= 1'b0;
    wait_boot(1'b0);
    rd(REG_STATUS, 32'h60);
    cmp_bit("ack_n", 1'b1, proc.ack_n);
    finish_boot();
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL, 32'h0);
    xmit <= 1'b1;
    cyc(60);
    xmit <= 1'b0;
    cmp_bit("boot_req_n", 1'b1, proc.boot_req_n);
    wr(REG_CTRL, 32'h3);
    wait_boot(1'b0);
    rd(REG_CTRL, 32'h1);
    finish_boot();
    carrier <= 1'b0;
    wait_boot(1'b0);
    finish_boot();
    carrier <= 1'b1;
    sw <= 1'b1;
    cyc(4);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) cmp_bit("boot_req_n", 1'b1, proc.boot_req_n);
      key <= 1'b1;
      cyc(1);
      key <= 1'b0;
      cyc(1);
    end
    wait_boot(1'b0);
    sw <= 1'b0;
    finish_boot();
    repeat (16) begin
      c = 8'($urandom);
      put(c == CODE_BOOT ? 8'h00 : c);
    end
    rd(REG_STATUS, 32'h0);
    cmp_bit("boot_req_n", 1'b1, proc.boot_req_n);
    cyc(4);
    results();
  end
endmodule
